// [rtl/cdee_host_ctrl.sv]
// Purpose: Requesting-node controller for coherency domain entry and exit.
// Assumes: All inputs synchronous to core_clk; the access port answers
//          each held request with a one-cycle cfg_ack.
// Notes:   Pin mode drives coreq; register mode polls and writes bits.
`timescale 1ns/1ns
`include "cdee_defs.svh"

// Notes on behaviour
// - Request/acknowledge levels 00,10,11,01 mean disabled, connect, enabled, disconnect.
// - After reset the node is disabled, request and acknowledge low.
// - Node raises request only when already able to answer snoops.
// - After dropping request the node keeps answering snoops.
// - A raised request stays high until acknowledge is seen high.
// - A dropped request stays low until acknowledge is seen low.
// - Request bit updates use read-modify-write, keeping other nodes' bits.
// - Entry: both bits read zero, node ready, then write request bit one.
// - Exit: both bits read one, then clear the request bit.
// - Status bit clears after responses; seen cleared before power down.
// - In register mode the request pin stays low.
// - In pin mode the request-control register is never written.
module cdee_host_ctrl
    import cdee_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    sw_mode_strap,
    input  wire logic                    join_req,
    input  wire logic                    leave_req,
    input  wire logic                    snoop_ready,
    output logic                         snoop_enable,
    output logic                         in_domain,
    output logic                         power_down_ok,
    output logic                         coreq,
    input  wire logic                    coack,
    output logic                         cfg_req,
    output cdee_cfg_req_s                cfg_cmd,
    input  wire logic                    cfg_ack,
    input  wire logic [`CDEE_DATA_W-1:0] cfg_rdata
);

    // ------------------------------------------------------------------
    // Mode strap
    // ------------------------------------------------------------------
    // The strap is caught by a clocked process after release, never by
    // the reset itself, so the mode holds until the next reset.
    logic mode_sw_reg;
    logic mode_sw_next;
    logic strap_taken_reg;
    logic strap_taken_next;

    always_comb
    begin
        mode_sw_next     = mode_sw_reg;
        strap_taken_next = 1'b1;
        if (!strap_taken_reg)
        begin
            mode_sw_next = sw_mode_strap;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_sw_reg     <= 1'b0;
            strap_taken_reg <= 1'b0;
        end
        else
        begin
            mode_sw_reg     <= mode_sw_next;
            strap_taken_reg <= strap_taken_next;
        end
    end

    // ------------------------------------------------------------------
    // Membership wish
    // ------------------------------------------------------------------
    logic want_reg;
    logic want_next;

    always_comb
    begin
        want_next = want_reg;
        if (join_req)
        begin
            want_next = 1'b1;
        end
        else if (leave_req)
        begin
            want_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            want_reg <= 1'b0;
        end
        else
        begin
            want_reg <= want_next;
        end
    end

    // ------------------------------------------------------------------
    // Handshake tracker
    // ------------------------------------------------------------------
    logic        stat_bit_reg;
    logic        ack_obs;
    logic        req_level;
    cdee_phase_e phase;

    // In register mode the polled status bit stands in for the pin.
    assign ack_obs = mode_sw_reg ? stat_bit_reg : coack;

    cdee_phase_tracker u_tracker (
        .core_clk     (core_clk),
        .rst          (rst),
        .want_in      (want_reg),
        .snoop_ready  (snoop_ready && strap_taken_reg),
        .ack_obs      (ack_obs),
        .req_level    (req_level),
        .phase        (phase),
        .snoop_enable (snoop_enable)
    );

    assign coreq         = req_level && !mode_sw_reg;
    assign in_domain     = (phase == CDEE_ENABLED);
    // Power down only once the acknowledge has been seen low.
    assign power_down_ok = (phase == CDEE_DISABLED) && !ack_obs;

    // ------------------------------------------------------------------
    // Register-mode access sequencer
    // ------------------------------------------------------------------
    cdee_bus_e                bus_state_reg;
    cdee_bus_e                bus_state_next;
    logic                     req_valid_reg;
    logic                     req_valid_next;
    cdee_cfg_req_s            cmd_reg;
    cdee_cfg_req_s            cmd_next;
    logic                     stat_bit_next;
    logic [`CDEE_DATA_W-1:0]  ctl_shadow_reg;
    logic [`CDEE_DATA_W-1:0]  ctl_shadow_next;
    logic                     ctl_bit_rd;
    logic                     set_ok;
    logic                     clr_ok;

    assign ctl_bit_rd = cfg_rdata[`CDEE_NODE_BIT];
    // Set only from 0/0, clear only from 1/1.
    assign set_ok = req_level && !ctl_bit_rd && !stat_bit_reg;
    assign clr_ok = !req_level && ctl_bit_rd && stat_bit_reg;

    always_comb
    begin
        bus_state_next  = bus_state_reg;
        req_valid_next  = req_valid_reg;
        cmd_next        = cmd_reg;
        stat_bit_next   = stat_bit_reg;
        ctl_shadow_next = ctl_shadow_reg;
        case (bus_state_reg)
            CDEE_BUS_IDLE:
            begin
                // Pin mode never touches the configuration space.
                if (strap_taken_reg && mode_sw_reg)
                begin
                    bus_state_next = CDEE_BUS_RD_ST;
                    req_valid_next = 1'b1;
                    cmd_next.write = 1'b0;
                    cmd_next.addr  = `CDEE_ACK_STAT_OFS;
                    cmd_next.wdata = `CDEE_REG_RST;
                end
            end
            CDEE_BUS_RD_ST:
            begin
                if (cfg_ack)
                begin
                    stat_bit_next  = cfg_rdata[`CDEE_NODE_BIT];
                    bus_state_next = CDEE_BUS_RD_CTL;
                    cmd_next.addr  = `CDEE_REQ_CTL_OFS;
                end
            end
            CDEE_BUS_RD_CTL:
            begin
                if (cfg_ack)
                begin
                    ctl_shadow_next = cfg_rdata;
                    cmd_next.addr   = `CDEE_ACK_STAT_OFS;
                    bus_state_next  = CDEE_BUS_RD_ST;
                    if (set_ok || clr_ok)
                    begin
                        // Other nodes' bits go back as they were read.
                        bus_state_next = CDEE_BUS_WR_CTL;
                        cmd_next.write = 1'b1;
                        cmd_next.addr  = `CDEE_REQ_CTL_OFS;
                        cmd_next.wdata = cfg_rdata;
                        cmd_next.wdata[`CDEE_NODE_BIT] = req_level;
                    end
                end
            end
            CDEE_BUS_WR_CTL:
            begin
                if (cfg_ack)
                begin
                    bus_state_next = CDEE_BUS_RD_ST;
                    cmd_next.write = 1'b0;
                    cmd_next.addr  = `CDEE_ACK_STAT_OFS;
                    cmd_next.wdata = `CDEE_REG_RST;
                end
            end
            default:
            begin
                bus_state_next = CDEE_BUS_IDLE;
                req_valid_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state_reg  <= CDEE_BUS_IDLE;
            req_valid_reg  <= 1'b0;
            cmd_reg        <= '0;
            stat_bit_reg   <= 1'b0;
            ctl_shadow_reg <= `CDEE_REG_RST;
        end
        else
        begin
            bus_state_reg  <= bus_state_next;
            req_valid_reg  <= req_valid_next;
            cmd_reg        <= cmd_next;
            stat_bit_reg   <= stat_bit_next;
            ctl_shadow_reg <= ctl_shadow_next;
        end
    end

    assign cfg_req = req_valid_reg;
    assign cfg_cmd = cmd_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_write_issue;
        $rose(cfg_req && cfg_cmd.write);
    endsequence

    property p_pin_low_in_sw;
        @(posedge core_clk) disable iff (rst)
        mode_sw_reg |-> !coreq;
    endproperty
    a_pin_low_in_sw: assert property (p_pin_low_in_sw)
        else $error("Request pin driven while in register mode.");

    property p_no_write_in_hw;
        @(posedge core_clk) disable iff (rst)
        !mode_sw_reg |-> !(cfg_req && cfg_cmd.write);
    endproperty
    a_no_write_in_hw: assert property (p_no_write_in_hw)
        else $error("Request-control write issued in pin mode.");

    property p_rmw_keeps_others;
        @(posedge core_clk) disable iff (rst)
        s_write_issue |-> (cfg_cmd.wdata ^ ctl_shadow_reg) ==
            (`CDEE_DATA_W'(1) << `CDEE_NODE_BIT);
    endproperty
    a_rmw_keeps_others: assert property (p_rmw_keeps_others)
        else $error("Write changed bits other than this node's.");

    property p_set_from_zero;
        @(posedge core_clk) disable iff (rst)
        s_write_issue ##0 cfg_cmd.wdata[`CDEE_NODE_BIT] |->
            !stat_bit_reg && !ctl_shadow_reg[`CDEE_NODE_BIT];
    endproperty
    a_set_from_zero: assert property (p_set_from_zero)
        else $error("Request bit set while bits were not both zero.");

    property p_clear_from_one;
        @(posedge core_clk) disable iff (rst)
        s_write_issue ##0 !cfg_cmd.wdata[`CDEE_NODE_BIT] |->
            stat_bit_reg && ctl_shadow_reg[`CDEE_NODE_BIT];
    endproperty
    a_clear_from_one: assert property (p_clear_from_one)
        else $error("Request bit cleared while bits were not both one.");

    property p_power_after_ack_low;
        @(posedge core_clk) disable iff (rst)
        power_down_ok |-> !ack_obs && !snoop_enable;
    endproperty
    a_power_after_ack_low: assert property (p_power_after_ack_low)
        else $error("Power down allowed with acknowledge still high.");

endmodule

// [rtl/cdee_defs.svh]
// Purpose: Constants for the coherency domain entry/exit controller.
// Assumes: Included by the package, the controller, the model and the bench; 32-bit configuration data.
// Notes:   Offsets address the interconnect's configuration space.
`ifndef CDEE_DEFS_SVH
`define CDEE_DEFS_SVH

// ----------------------------------------------------------------------
// Configuration space layout
// ----------------------------------------------------------------------
`define CDEE_ADDR_W          16
`define CDEE_DATA_W          32
`define CDEE_REQ_CTL_OFS     16'h0000
`define CDEE_ACK_STAT_OFS    16'h0004

// ----------------------------------------------------------------------
// Node selection and reset values
// ----------------------------------------------------------------------
`define CDEE_NODE_BIT        5'h00
`define CDEE_REG_RST         32'h0000_0000

`endif

// [rtl/cdee_pkg.sv]
// Purpose: Types shared by the coherency entry/exit controller files.
// Assumes: cdee_defs.svh supplies every width and offset.
// Notes:   State codes are one-hot and written out in full.
package cdee_pkg;

`include "cdee_defs.svh"

    // ------------------------------------------------------------------
    // Handshake phases of the request/acknowledge pair
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CDEE_DISABLED   = 4'b0001,
        CDEE_CONNECT    = 4'b0010,
        CDEE_ENABLED    = 4'b0100,
        CDEE_DISCONNECT = 4'b1000
    } cdee_phase_e;

    // ------------------------------------------------------------------
    // Configuration access sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CDEE_BUS_IDLE   = 4'b0001,
        CDEE_BUS_RD_ST  = 4'b0010,
        CDEE_BUS_RD_CTL = 4'b0100,
        CDEE_BUS_WR_CTL = 4'b1000
    } cdee_bus_e;

    typedef struct packed {
        logic                     write;
        logic [`CDEE_ADDR_W-1:0]  addr;
        logic [`CDEE_DATA_W-1:0]  wdata;
    } cdee_cfg_req_s;

endpackage

// [rtl/cdee_phase_tracker.sv]
// Purpose: Requester side of the four-phase coherency handshake.
// Assumes: ack_obs is synchronous to core_clk.
// Notes:   req_level is the request the node presents, by pin or bit.
`timescale 1ns/1ns

module cdee_phase_tracker
    import cdee_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        want_in,
    input  wire logic        snoop_ready,
    input  wire logic        ack_obs,
    output logic             req_level,
    output cdee_phase_e      phase,
    output logic             snoop_enable
);

    cdee_phase_e phase_reg;
    cdee_phase_e phase_next;
    logic        req_reg;
    logic        req_next;

    // ------------------------------------------------------------------
    // Next phase
    // ------------------------------------------------------------------
    always_comb
    begin
        phase_next = phase_reg;
        req_next   = req_reg;
        case (phase_reg)
            CDEE_DISABLED:
            begin
                // Raise only once snoops can be answered.
                if (want_in && snoop_ready && !ack_obs)
                begin
                    phase_next = CDEE_CONNECT;
                    req_next   = 1'b1;
                end
            end
            CDEE_CONNECT:
            begin
                // Request stays high until the acknowledge arrives.
                if (ack_obs)
                begin
                    phase_next = CDEE_ENABLED;
                end
            end
            CDEE_ENABLED:
            begin
                if (!want_in)
                begin
                    phase_next = CDEE_DISCONNECT;
                    req_next   = 1'b0;
                end
            end
            CDEE_DISCONNECT:
            begin
                // Request stays low until the acknowledge drops.
                if (!ack_obs)
                begin
                    phase_next = CDEE_DISABLED;
                end
            end
            default:
            begin
                phase_next = CDEE_DISABLED;
                req_next   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_reg <= CDEE_DISABLED;
            req_reg   <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            req_reg   <= req_next;
        end
    end

    assign req_level    = req_reg;
    assign phase        = phase_reg;
    // Snoops are answered from the raise until the acknowledge drops.
    assign snoop_enable = (phase_reg != CDEE_DISABLED);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_req_held_high;
        @(posedge core_clk) disable iff (rst)
        (req_reg && !ack_obs) |=> req_reg;
    endproperty
    a_req_held_high: assert property (p_req_held_high)
        else $error("Request dropped before acknowledge rose.");

    property p_req_held_low;
        @(posedge core_clk) disable iff (rst)
        (!req_reg && ack_obs) |=> !req_reg;
    endproperty
    a_req_held_low: assert property (p_req_held_low)
        else $error("Request raised before acknowledge fell.");

    property p_raise_when_ready;
        @(posedge core_clk) disable iff (rst)
        $rose(req_reg) |-> $past(snoop_ready) && snoop_enable;
    endproperty
    a_raise_when_ready: assert property (p_raise_when_ready)
        else $error("Request raised while node could not snoop.");

    property p_phase_encoding;
        @(posedge core_clk) disable iff (rst)
        (phase_reg == CDEE_DISABLED || phase_reg == CDEE_DISCONNECT)
            == !req_reg;
    endproperty
    a_phase_encoding: assert property (p_phase_encoding)
        else $error("Phase and request level disagree.");

    property p_snoop_in_disconnect;
        @(posedge core_clk) disable iff (rst)
        (phase_reg == CDEE_DISCONNECT) |-> snoop_enable;
    endproperty
    a_snoop_in_disconnect: assert property (p_snoop_in_disconnect)
        else $error("Snoop answering stopped during disconnect.");

endmodule

// [sim/cdee_dev_model.sv]
// Purpose: Interconnect model for the coherency entry/exit handshake.
// Assumes: The host under test owns node bit 0 only.
// Notes:   ack_dly stands for outstanding snoop responses and bus wait.
`timescale 1ns/1ns
`include "cdee_defs.svh"

module cdee_dev_model
    import cdee_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic [7:0]              ack_dly,
    input  wire logic [30:0]             other_req,
    input  wire logic                    coreq,
    output logic                         coack,
    input  wire logic                    cfg_req,
    input  wire cdee_cfg_req_s           cfg_cmd,
    output logic                         cfg_ack,
    output logic [`CDEE_DATA_W-1:0]      cfg_rdata,
    output logic [`CDEE_DATA_W-1:0]      last_wdata,
    output logic [7:0]                   wr_count
);
    logic                    sw_reg;
    logic                    ack_reg;
    logic                    want;
    logic                    take;
    logic                    wr_hit;
    logic [7:0]              hs_cnt;
    logic [7:0]              bus_cnt;
    logic [`CDEE_DATA_W-1:0] ctl_reg;
    logic [`CDEE_DATA_W-1:0] rd_val;

    // --------------------------------
    // Handshake and register file
    // --------------------------------
    // Bits of other nodes answer at once and never touch bit 0.
    assign want   = sw_reg ? ctl_reg[0] : coreq;
    assign coack  = sw_reg ? 1'b0 : ack_reg;
    assign take   = cfg_req && !cfg_ack && bus_cnt >= ack_dly;
    assign wr_hit = cfg_cmd.write && cfg_cmd.addr == `CDEE_REQ_CTL_OFS;
    assign rd_val = (cfg_cmd.addr == `CDEE_ACK_STAT_OFS) ?
                    {ctl_reg[31:1], ack_reg} :
                    ((cfg_cmd.addr == `CDEE_REQ_CTL_OFS) ? ctl_reg : '0);
    // Released data lines show the inverse, so a stale sample is caught.
    assign cfg_rdata = cfg_ack ? rd_val : ~rd_val;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sw_reg     <= 1'b0;
            ack_reg    <= 1'b0;
            hs_cnt     <= 8'h00;
            bus_cnt    <= 8'h00;
            ctl_reg    <= `CDEE_REG_RST;
            cfg_ack    <= 1'b0;
            last_wdata <= '0;
            wr_count   <= 8'h00;
        end
        else
        begin
            hs_cnt <= (want != ack_reg && hs_cnt < ack_dly) ?
                      hs_cnt + 8'h01 : 8'h00;
            if (want != ack_reg && hs_cnt >= ack_dly)
                ack_reg <= want;
            bus_cnt <= (cfg_req && !cfg_ack && !take) ?
                       bus_cnt + 8'h01 : 8'h00;
            cfg_ack       <= take;
            ctl_reg[31:1] <= other_req;
            if (take && wr_hit)
            begin
                ctl_reg[0] <= cfg_cmd.wdata[0];
                sw_reg     <= 1'b1;
                last_wdata <= cfg_cmd.wdata;
                wr_count   <= wr_count + 8'h01;
            end
        end
    end
endmodule

// [sim/tb_cdee_host_ctrl.sv]
// Purpose: Self-checking bench for the coherency entry/exit controller.
// Assumes: cdee_dev_model plays the interconnect on both interfaces.
// Notes:   Inputs change 1 ns after each rising edge of core_clk.
`timescale 1ns/1ns
`include "cdee_defs.svh"

module tb_cdee_host_ctrl;
    import cdee_pkg::*;

    logic                    core_clk;
    logic                    rst;
    logic                    sw_mode_strap;
    logic                    join_req;
    logic                    leave_req;
    logic                    snoop_ready;
    logic                    snoop_enable;
    logic                    in_domain;
    logic                    power_down_ok;
    logic                    coreq;
    logic                    coack;
    logic                    cfg_req;
    cdee_cfg_req_s           cfg_cmd;
    logic                    cfg_ack;
    logic [`CDEE_DATA_W-1:0] cfg_rdata;
    logic [`CDEE_DATA_W-1:0] last_wdata;
    logic [7:0]              wr_count;
    logic [7:0]              ack_dly;
    logic [30:0]             other_req;
    logic                    prev_req;
    logic                    prev_ack;
    int                      fail_count;
    int                      num_checks;
    int                      cycles = 0;

    cdee_host_ctrl u_dut (.core_clk(core_clk), .rst(rst),
        .sw_mode_strap(sw_mode_strap), .join_req(join_req),
        .leave_req(leave_req), .snoop_ready(snoop_ready),
        .snoop_enable(snoop_enable), .in_domain(in_domain),
        .power_down_ok(power_down_ok), .coreq(coreq), .coack(coack),
        .cfg_req(cfg_req), .cfg_cmd(cfg_cmd), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));

    cdee_dev_model u_dev (.core_clk(core_clk), .rst(rst),
        .ack_dly(ack_dly), .other_req(other_req), .coreq(coreq),
        .coack(coack), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .last_wdata(last_wdata), .wr_count(wr_count));

    // --------------------------------
    // Checking helpers
    // --------------------------------
    task automatic chk(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask

    task automatic chkw(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return coreq;
            1: return in_domain;
            2: return power_down_ok;
            3: return coack;
            default: return wr_count[0];
        endcase
    endfunction

    // A bounded wait, so a stuck handshake shows as a mismatch.
    task automatic wait_for(input string nm, input int w, input logic lvl);
        int n;
        n = 0;
        while (pick(w) !== lvl && n < 200)
        begin
            cyc(1);
            n++;
        end
        chk(nm, lvl, pick(w));
    endtask

    task automatic do_reset(input logic strap);
        rst = 1'b1;
        sw_mode_strap = strap;
        join_req = 1'b0;
        leave_req = 1'b0;
        cyc(2);
        chk("coreq in reset", 1'b0, coreq);
        chk("in_domain in reset", 1'b0, in_domain);
        chk("snoop_enable in reset", 1'b0, snoop_enable);
        chk("cfg_req in reset", 1'b0, cfg_req);
        chk("power_down_ok in reset", 1'b1, power_down_ok);
        rst = 1'b0;
    endtask

    task automatic pulse_join();
        join_req = 1'b1;
        cyc(1);
        join_req = 1'b0;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_pin_basic();
        do_reset(1'b0);
        ack_dly = 8'h03;
        snoop_ready = 1'b0;
        pulse_join();
        cyc(4);
        chk("coreq before ready", 1'b0, coreq);
        snoop_ready = 1'b1;
        wait_for("coreq raised", 0, 1'b1);
        chk("snoop_enable connect", 1'b1, snoop_enable);
        wait_for("in_domain", 1, 1'b1);
        leave_req = 1'b1;
        wait_for("coreq dropped", 0, 1'b0);
        leave_req = 1'b0;
        chk("snoop_enable disconnect", 1'b1, snoop_enable);
        wait_for("coack dropped", 3, 1'b0);
        wait_for("power_down_ok", 2, 1'b1);
        chk("snoop_enable disabled", 1'b0, snoop_enable);
        $display("test pin_basic done");
    endtask

    task automatic t_pin_slow();
        do_reset(1'b0);
        ack_dly = 8'h14;
        snoop_ready = 1'b1;
        pulse_join();
        wait_for("coreq raised", 0, 1'b1);
        leave_req = 1'b1;
        wait_for("in_domain slow", 1, 1'b1);
        wait_for("coreq dropped", 0, 1'b0);
        leave_req = 1'b0;
        pulse_join();
        chk("coreq low in disconnect", 1'b0, coreq);
        wait_for("coack dropped", 3, 1'b0);
        wait_for("coreq rejoin", 0, 1'b1);
        wait_for("in_domain rejoin", 1, 1'b1);
        $display("test pin_slow done");
    endtask

    task automatic t_sw_cycle();
        do_reset(1'b1);
        ack_dly = 8'h02;
        snoop_ready = 1'b0;
        other_req = 31'h2AAA_AAAA;
        pulse_join();
        cyc(30);
        chk("write before ready", 1'b0, |wr_count);
        snoop_ready = 1'b1;
        wait_for("join write", 4, 1'b1);
        chkw("join data", {other_req, 1'b1}, last_wdata);
        wait_for("in_domain sw", 1, 1'b1);
        chk("coreq in reg mode", 1'b0, coreq);
        leave_req = 1'b1;
        wait_for("leave write", 4, 1'b0);
        leave_req = 1'b0;
        chkw("leave data", {other_req, 1'b0}, last_wdata);
        wait_for("power_down_ok sw", 2, 1'b1);
        chk("snoop_enable sw off", 1'b0, snoop_enable);
        $display("test sw_cycle done");
    endtask

    // --------------------------------
    // Pin monitor, clock and sequence
    // --------------------------------
    always @(posedge core_clk)
    begin
        if (!rst)
        begin
            if (prev_req && !coreq && !prev_ack)
                chk("coreq held high", 1'b1, coreq);
            if (!prev_req && coreq && prev_ack)
                chk("coreq held low", 1'b0, coreq);
            // The interconnect may snoop whenever either pin is high.
            if (!sw_mode_strap && (coreq || coack))
                chk("snoop_enable member", 1'b1, snoop_enable);
            if (sw_mode_strap)
                chk("coreq reg mode", 1'b0, coreq);
            else
                chk("cfg_req pin mode", 1'b0, cfg_req);
        end
        prev_req <= coreq;
        prev_ack <= coack;
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        rst = 1'b1;
        sw_mode_strap = 1'b0;
        join_req = 1'b0;
        leave_req = 1'b0;
        snoop_ready = 1'b0;
        ack_dly = 8'h03;
        other_req = '0;
        fail_count = 0;
        num_checks = 0;
        t_pin_basic();
        t_pin_slow();
        t_sw_cycle();
        final_report();
    end
endmodule
